// [hw/rtc_defines.svh]
// Address map, field positions, reset values and rate constants of the clock block.
`ifndef RTC_DEFINES_SVH
`define RTC_DEFINES_SVH
`define ADR_HUND 5'h00
`define ADR_HOURS 5'h01
`define ADR_MIN 5'h02
`define ADR_SEC 5'h03
`define ADR_MONTH 5'h04
`define ADR_DATE 5'h05
`define ADR_YEAR 5'h06
`define ADR_DOW 5'h07
`define ADR_ALARM_BASE 5'h08
`define ADR_IRQ 5'h10
`define ADR_CMD 5'h11
`define CMD_FSEL_LSB 0
`define CMD_24H 2
`define CMD_RUN 3
`define CMD_IRQ_EN 4
`define CMD_TEST 5
`define EV_ALARM 0
`define EV_HUND 1
`define EV_TENTH 2
`define EV_SEC 3
`define EV_MIN 4
`define EV_HOUR 5
`define EV_DAY 6
`define STAT_PEND 7
`define HOURS_PM 7
`define ALARM_IGN_HOURS 6
`define ALARM_IGN 7
`define MASK_RESET 8'h00
`define CMD_RESET 8'h00
`define F_XTAL_0 23'd32768
`define F_XTAL_1 23'd1048576
`define F_XTAL_2 23'd2097152
`define F_XTAL_3 23'd4194304
`define RATE_PRE_HZ 23'd4000
`define RATE_TICK_HZ 23'd100
`define TICK_DIV 6'd40
`define SNAP_BITS 36
`endif

// [hw/rtc_pkg.sv]
// Shared types of the clock block.
package rtc_pkg;
   // One host access as seen after pin synchronisation and address latching.
   typedef struct packed {
      logic rd_act;
      logic rd_start;
      logic rd_end;
      logic wr_act;
      logic [4:0] addr;
      logic [7:0] wdata;
   } bus_req_t;
   typedef logic [7:0][7:0] word_bank_t;
endpackage

// [hw/rtc_tick_gen.sv]
// Crystal prescaler: crystal edges to a 4000Hz step, then to the 100Hz tick.
`timescale 1ns/1ns
`include "rtc_defines.svh"
module rtc_tick_gen (
   input wire logic clk,
   input wire logic rstn,
   input wire logic xtal_pin,
   input wire logic [1:0] fsel,
   output logic tick
);
   import rtc_pkg::*;
   logic [2:0] xs_ff;
   logic [22:0] acc_ff;
   logic [5:0] div_ff;
   logic tick_ff;
   wire xtal_rise = xs_ff[1] & ~xs_ff[2];
   wire [22:0] f_sel = (fsel == 2'd0) ? `F_XTAL_0 : (fsel == 2'd1) ? `F_XTAL_1 :
                       (fsel == 2'd2) ? `F_XTAL_2 : `F_XTAL_3;
   wire [22:0] acc_sum = acc_ff + `RATE_PRE_HZ;
   // A fractional accumulator keeps the long-run average exact for every crystal, at the price of jitter.
   wire pre_step = xtal_rise & (acc_sum >= f_sel);
   wire [22:0] nxt_acc = xtal_rise ? (pre_step ? acc_sum - f_sel : acc_sum) : acc_ff;
   wire div_wrap = pre_step & (div_ff == `TICK_DIV - 6'd1);
   wire [5:0] nxt_div = div_wrap ? 6'h00 : (pre_step ? div_ff + 6'd1 : div_ff);

   // Only bit 1 and the edge stage behind it feed logic; bit 0 is the bare synchroniser input.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         xs_ff <= 3'h0;
         acc_ff <= 23'h000000;
         div_ff <= 6'h00;
         tick_ff <= 1'b0;
      end else begin
         xs_ff <= {xs_ff[1:0], xtal_pin};
         acc_ff <= nxt_acc;
         div_ff <= nxt_div;
         tick_ff <= div_wrap;
      end
   end
   assign tick = tick_ff;
endmodule

// [hw/rtc_bus_port.sv]
// Host bus front end: strobe synchronisers and the multiplexed address latch.
`timescale 1ns/1ns
`include "rtc_defines.svh"
module rtc_bus_port (
   input wire logic clk,
   input wire logic rstn,
   input wire logic rd_n_pin,
   input wire logic wr_n_pin,
   input wire logic cs_n_pin,
   input wire logic ale_pin,
   input wire logic [4:0] addr_pin,
   input wire logic [7:0] data_pin,
   output rtc_pkg::bus_req_t req
);
   import rtc_pkg::*;
   logic [16:0] s1_ff;
   logic [16:0] s2_ff;
   logic [4:0] adr_lat_ff;
   logic cs_lat_ff;
   logic rd_q_ff;
   wire rd_s = ~s2_ff[0];
   wire wr_s = ~s2_ff[1];
   wire cs_s = ~s2_ff[2];
   wire ale_s = s2_ff[3];
   wire [4:0] adr_s = s2_ff[8:4];
   // While the latch strobe is high address and select pass through; its fall freezes both.
   wire cs_eff = ale_s ? cs_s : cs_lat_ff;
   wire [4:0] adr_eff = ale_s ? adr_s : adr_lat_ff;
   // A strobe counts only together with chip select.
   wire rd_now = rd_s & cs_eff;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s1_ff <= 17'h0000f;
         s2_ff <= 17'h0000f;
         adr_lat_ff <= 5'h00;
         cs_lat_ff <= 1'b0;
         rd_q_ff <= 1'b0;
      end else begin
         s1_ff <= {data_pin, addr_pin, ale_pin, cs_n_pin, wr_n_pin, rd_n_pin};
         s2_ff <= s1_ff;
         if (ale_s) begin
            adr_lat_ff <= adr_s;
            cs_lat_ff <= cs_s;
         end
         rd_q_ff <= rd_now;
      end
   end

   assign req.rd_act = rd_now;
   assign req.rd_start = rd_now & ~rd_q_ff;
   assign req.rd_end = ~rd_now & rd_q_ff;
   assign req.wr_act = wr_s & cs_eff;
   assign req.addr = adr_eff;
   assign req.wdata = s2_ff[16:9];
endmodule

// [hw/rtc_core.sv]
// Real-time clock core: counters, alarm words, snapshot latch, interrupt logic and register access.
`timescale 1ns/1ns
`include "rtc_defines.svh"
// What this block does
// - Addresses 12h to 1Fh are unused; writes ignored, reads return zero.
// - In 12-hour format the hours top bit flags afternoon.
// - Alarm word joins the match only while its ignore bit is zero.
// - Write-only mask at 10h enables day, hour, minute, second, tenth, hundredth, alarm.
// - Reading 10h returns cause flags; bit 7 says an interrupt is pending.
// - Interrupt output may assert whenever command interrupt enable is set, even in standby.
// - During power-down only counting and interrupts continue; bus accesses are ignored.
// - Command bit 3 lets the 100Hz tick advance the counters or holds them.
// - Reading the hundredths counter copies all counters into the snapshot latch.
// - A tick arriving during a read is deferred until the read ends.
// - Other counters read from the snapshot until hundredths is read again.
// - Data lines driven only while read strobe and chip select are both low.
// - Data loads into the addressed register while write strobe and chip select are low.
// - Multiplexed bus: address and chip select captured at the latch strobe's fall.
// - Command bit 5 feeds the 100Hz tick straight into the seconds counter.
// - Reading the status register releases the interrupt output.
// - An all-zero mask produces no periodic or alarm interrupts.
// - Interrupt assertion shows as a falling edge at the selected period.
// - Command 11h holds crystal select in bits 1:0 and 24-hour mode in bit 2.
// - The prescaled 4000Hz step is divided to the 100Hz counter tick.
// - Masked roll-overs set status bits; status clears at the read strobe's trailing edge.
// - Counters sit at 00h-07h, alarm words at 08h-0Fh; unused counter bits read zero, alarm words keep all eight bits.
module rtc_core (
   input wire logic CLK_SYS,
   input wire logic RSTN,
   input wire logic XTAL_IN,
   input wire logic PWR_DOWN,
   input wire logic RD_N,
   input wire logic WR_N,
   input wire logic CS_N,
   input wire logic ALE,
   input wire logic [4:0] ADDR,
   input wire logic [7:0] DATA_IN,
   output logic [7:0] DATA_OUT,
   output logic DATA_OE,
   output logic IRQ_OUT,
   output logic IRQ_OE
);
   import rtc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // Declarations and submodules.
   bus_req_t req;
   logic tick;
   logic [1:0] pd_ff;
   word_bank_t cnt_ff;
   word_bank_t nxt_cnt;
   word_bank_t alarm_ff;
   word_bank_t snap_ff;
   logic [7:0] mask_ff;
   logic [7:0] cmd_ff;
   logic [6:0] stat_ff;
   logic [7:0] rdata_ff;
   logic pend_ff;
   logic adv_q_ff;

   // The tick generator always follows the crystal select, also in power-down.
   rtc_tick_gen u_tick (
      .clk(CLK_SYS),
      .rstn(RSTN),
      .xtal_pin(XTAL_IN),
      .fsel(cmd_ff[`CMD_FSEL_LSB +: 2]),
      .tick(tick)
   );

   rtc_bus_port u_bus (
      .clk(CLK_SYS),
      .rstn(RSTN),
      .rd_n_pin(RD_N),
      .wr_n_pin(WR_N),
      .cs_n_pin(CS_N),
      .ale_pin(ALE),
      .addr_pin(ADDR),
      .data_pin(DATA_IN),
      .req(req)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Access qualification and decode.
   wire pd = pd_ff[1];
   // Power-down shuts the bus out entirely; counting and interrupts carry on.
   wire rd_ok = req.rd_act & ~pd;
   wire wr_ok = req.wr_act & ~pd;
   wire [4:0] a = req.addr;
   wire a_cnt = (a[4:3] == 2'b00);
   wire a_alarm = (a[4:3] == 2'b01);
   wire wr_mask = wr_ok & (a == `ADR_IRQ);
   wire wr_cmd = wr_ok & (a == `ADR_CMD);
   wire run = cmd_ff[`CMD_RUN];
   wire h24 = cmd_ff[`CMD_24H];
   wire test = cmd_ff[`CMD_TEST];

   ////////////////////////////////////////////////////////////////////////////////
   // Tick deferral and counter chain.
   // A tick is held while a read is under way so the snapshot never tears.
   wire tick_go = pend_ff & run & ~rd_ok;
   // Test mode bypasses the hundredths stage.
   wire adv_hund = tick_go & ~test;
   wire [7:0] hund = cnt_ff[`ADR_HUND];
   wire [7:0] hr = cnt_ff[`ADR_HOURS];
   wire [7:0] mon = cnt_ff[`ADR_MONTH];
   wire [7:0] yr = cnt_ff[`ADR_YEAR];
   wire hund_wrap = adv_hund & (hund == 8'd99);
   // The counter is binary, so the tenth step needs the remainder, not the low nibble.
   wire [7:0] hund_rem = hund % 8'd10;
   wire tenth_ev = adv_hund & (hund_rem == 8'd9);
   wire adv_sec = test ? tick_go : hund_wrap;
   wire sec_wrap = adv_sec & (cnt_ff[`ADR_SEC] == 8'd59);
   wire min_wrap = sec_wrap & (cnt_ff[`ADR_MIN] == 8'd59);
   wire [4:0] hr_v = hr[4:0];
   // In 12-hour format 11 to 12 flips the afternoon flag and 12 wraps to 1.
   wire hr_top = h24 ? (hr_v == 5'd23) : (hr_v == 5'd12);
   wire pm_flip = min_wrap & ~h24 & (hr_v == 5'd11);
   wire day_wrap = h24 ? (min_wrap & hr_top) : (pm_flip & hr[`HOURS_PM]);
   wire leap = (yr[1:0] == 2'b00);
   wire [7:0] dim = (mon == 8'd2) ? (leap ? 8'd29 : 8'd28) :
                    ((mon == 8'd4) | (mon == 8'd6) | (mon == 8'd9) | (mon == 8'd11)) ? 8'd30 : 8'd31;
   wire date_wrap = day_wrap & (cnt_ff[`ADR_DATE] >= dim);
   wire mon_wrap = date_wrap & (mon == 8'd12);
   // Each periodic flag follows the carry into its counter: 100Hz, 10Hz, second, minute, hour and day.
   wire [6:1] ev_per = {day_wrap, min_wrap, sec_wrap, adv_sec, tenth_ev, adv_hund};
   // Valid data bits of each counter word; the rest read zero and ignore writes.
   wire [7:0] wmask [8];
   assign wmask[0] = 8'h7f;
   assign wmask[1] = h24 ? 8'h1f : 8'h9f;
   assign wmask[2] = 8'h3f;
   assign wmask[3] = 8'h3f;
   assign wmask[4] = 8'h0f;
   assign wmask[5] = 8'h1f;
   assign wmask[6] = 8'h7f;
   assign wmask[7] = 8'h07;

   // Host writes win over counting in the same cycle.
   always_comb begin
      nxt_cnt = cnt_ff;
      if (adv_hund) nxt_cnt[`ADR_HUND] = hund_wrap ? 8'h00 : hund + 8'd1;
      if (adv_sec) nxt_cnt[`ADR_SEC] = sec_wrap ? 8'h00 : cnt_ff[`ADR_SEC] + 8'd1;
      if (sec_wrap) nxt_cnt[`ADR_MIN] = min_wrap ? 8'h00 : cnt_ff[`ADR_MIN] + 8'd1;
      if (min_wrap) begin
         if (h24) begin
            nxt_cnt[`ADR_HOURS] = hr_top ? 8'h00 : {3'b000, hr_v + 5'd1};
         end else begin
            nxt_cnt[`ADR_HOURS] = {hr[`HOURS_PM] ^ pm_flip, 2'b00, hr_top ? 5'd1 : hr_v + 5'd1};
         end
      end
      if (day_wrap) begin
         nxt_cnt[`ADR_DOW] = (cnt_ff[`ADR_DOW] >= 8'd6) ? 8'h00 : cnt_ff[`ADR_DOW] + 8'd1;
         nxt_cnt[`ADR_DATE] = date_wrap ? 8'd1 : cnt_ff[`ADR_DATE] + 8'd1;
      end
      if (date_wrap) nxt_cnt[`ADR_MONTH] = mon_wrap ? 8'd1 : mon + 8'd1;
      if (mon_wrap) nxt_cnt[`ADR_YEAR] = (yr >= 8'd99) ? 8'h00 : yr + 8'd1;
      if (wr_ok & a_cnt) nxt_cnt[a[2:0]] = req.wdata & wmask[a[2:0]];
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Alarm compare and interrupt flags.
   logic [7:0] word_hit;
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_cmp
         localparam int IGN = (gi == 1) ? `ALARM_IGN_HOURS : `ALARM_IGN;
         wire [7:0] cmp_bits = wmask[gi] & ~(8'h01 << IGN);
         // An ignore bit of one drops the word from the match.
         assign word_hit[gi] = alarm_ff[gi][IGN] | ((alarm_ff[gi] & cmp_bits) == (cnt_ff[gi] & cmp_bits));
      end
   endgenerate
   // Checked the cycle after the counters moved, i.e. against the new time.
   wire alarm_ev = adv_q_ff & (&word_hit);
   wire [6:0] ev_all = {ev_per[6:1], alarm_ev};
   // Only enabled sources may set a flag, so a zero mask raises nothing.
   wire [6:0] stat_set = ev_all & mask_ff[6:0];
   wire stat_clr = req.rd_end & ~pd & (a == `ADR_IRQ);
   // A flag set in the clearing cycle survives.
   wire [6:0] nxt_stat = (stat_ff & {7{~stat_clr}}) | stat_set;
   wire irq_any = |stat_ff;
   wire [4:0] rd_sel = a;

   ////////////////////////////////////////////////////////////////////////////////
   // Read data selection.
   // Hundredths reads live; other counters come from the snapshot.
   wire [7:0] rd_mux = (rd_sel == `ADR_HUND) ? hund :
                       a_cnt ? snap_ff[rd_sel[2:0]] :
                       a_alarm ? alarm_ff[rd_sel[2:0]] :
                       (rd_sel == `ADR_IRQ) ? {irq_any, stat_ff} : 8'h00;

   ////////////////////////////////////////////////////////////////////////////////
   // State registers.
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         pd_ff <= 2'b00;
         cnt_ff <= {8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
         alarm_ff <= '0;
         snap_ff <= '0;
         mask_ff <= `MASK_RESET;
         cmd_ff <= `CMD_RESET;
         stat_ff <= 7'h00;
         rdata_ff <= 8'h00;
         pend_ff <= 1'b0;
         adv_q_ff <= 1'b0;
      end else begin
         pd_ff <= {pd_ff[0], PWR_DOWN};
         cnt_ff <= nxt_cnt;
         if (wr_ok & a_alarm) alarm_ff[a[2:0]] <= req.wdata;
         // The read strobe's leading edge at hundredths freezes every counter.
         if (req.rd_start & ~pd & (a == `ADR_HUND)) snap_ff <= cnt_ff;
         if (wr_mask) mask_ff <= {1'b0, req.wdata[6:0]};
         if (wr_cmd) cmd_ff <= {2'b00, req.wdata[5:0]};
         stat_ff <= nxt_stat;
         rdata_ff <= rd_mux;
         // Tick pending is set first; a stopped clock drops it.
         pend_ff <= tick | (pend_ff & ~tick_go & run);
         adv_q_ff <= tick_go;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Pins.
   assign DATA_OUT = rdata_ff;
   assign DATA_OE = rd_ok;
   // Open drain: only pulls low, and works whatever the power state.
   assign IRQ_OUT = 1'b0;
   assign IRQ_OE = cmd_ff[`CMD_IRQ_EN] & irq_any;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks.
   property p_unused_wr;
      @(posedge CLK_SYS) disable iff (!RSTN)
      (wr_ok & (a >= 5'h12)) |=> ($stable(mask_ff) && $stable(cmd_ff) && $stable(alarm_ff));
   endproperty
   a_unused_wr: assert property (p_unused_wr) else $error("unused address write changed state");

   property p_mask_zero;
      @(posedge CLK_SYS) disable iff (!RSTN)
      (mask_ff == 8'h00 && !irq_any) |=> !irq_any;
   endproperty
   a_mask_zero: assert property (p_mask_zero) else $error("flag raised with zero mask");

   property p_pd_bus;
      @(posedge CLK_SYS) disable iff (!RSTN)
      pd |-> !DATA_OE ##1 $stable(mask_ff);
   endproperty
   a_pd_bus: assert property (p_pd_bus) else $error("bus active in power-down");

   property p_stop_hold;
      @(posedge CLK_SYS) disable iff (!RSTN)
      (!run && !wr_ok) |=> (cnt_ff == $past(cnt_ff));
   endproperty
   a_stop_hold: assert property (p_stop_hold) else $error("counters moved while stopped");

   property p_snap_hold;
      @(posedge CLK_SYS) disable iff (!RSTN)
      !(req.rd_start & (a == `ADR_HUND)) |=> $stable(snap_ff);
   endproperty
   a_snap_hold: assert property (p_snap_hold) else $error("snapshot changed without hundredths read");

   property p_defer;
      @(posedge CLK_SYS) disable iff (!RSTN)
      (rd_ok && pend_ff && run) |=> pend_ff;
   endproperty
   a_defer: assert property (p_defer) else $error("tick lost during read");

   property p_irq_pin;
      @(posedge CLK_SYS) disable iff (!RSTN)
      (cmd_ff[`CMD_IRQ_EN] && stat_ff != 7'h00) |-> IRQ_OE;
   endproperty
   a_irq_pin: assert property (p_irq_pin) else $error("interrupt not asserted");

   property p_stat_clear;
      @(posedge CLK_SYS) disable iff (!RSTN)
      (stat_clr && stat_set == 7'h00) |=> (stat_ff == 7'h00);
   endproperty
   a_stat_clear: assert property (p_stat_clear) else $error("status not cleared by read");

   property p_oe_strobe;
      @(posedge CLK_SYS) disable iff (!RSTN)
      DATA_OE |-> (!$past(RD_N, 2) || !$past(RD_N, 3));
   endproperty
   a_oe_strobe: assert property (p_oe_strobe) else $error("data driven without read strobe");

   property p_tenth_flag;
      @(posedge CLK_SYS) disable iff (!RSTN)
      (adv_hund && hund == 8'd19 && mask_ff[`EV_TENTH]) |=> stat_ff[`EV_TENTH];
   endproperty
   a_tenth_flag: assert property (p_tenth_flag) else $error("tenth flag missed");

   property p_sec_flag;
      @(posedge CLK_SYS) disable iff (!RSTN)
      (!test && hund_wrap && mask_ff[`EV_SEC]) |=> stat_ff[`EV_SEC];
   endproperty
   a_sec_flag: assert property (p_sec_flag) else $error("second flag missed");

   property p_test_hold;
      @(posedge CLK_SYS) disable iff (!RSTN)
      (test && !wr_ok) |=> $stable(cnt_ff[`ADR_HUND]);
   endproperty
   a_test_hold: assert property (p_test_hold) else $error("hundredths moved in test mode");
endmodule

// [sim/rtc_host_model.sv]
// Microprocessor model driving the clock block's parallel or multiplexed bus.
`timescale 1ns/1ns
module rtc_host_model (
   input wire logic clk,
   input wire logic [7:0] data_out,
   input wire logic data_oe,
   output logic rd_n,
   output logic wr_n,
   output logic cs_n,
   output logic ale,
   output logic [4:0] addr,
   output logic [7:0] data_in
);
   ////////////////////////////////////////////////////////////////////////////////
   // Idle bus: strobes high and the latch transparent, as on a plain bus.
   initial begin
      rd_n = 1'b1;
      wr_n = 1'b1;
      cs_n = 1'b1;
      ale = 1'b1;
      addr = 5'h1f;
      data_in = 8'h00;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Ends a cycle: waits for the data lines to float, then scrambles the released lines.
   task automatic finish_cycle();
      int n;
      n = 0;
      while (data_oe !== 1'b0 && n < 12) begin
         @(negedge clk);
         n++;
      end
      if (data_oe !== 1'b0) begin
         rtc_bus_interrupt_latch_tb.timeout_hit();
      end
      addr = ~addr;
      data_in = ~data_in;
      repeat (12) @(negedge clk);
   endtask
   // Read cycle; chip select brackets the strobe so the select never drops under it.
   task automatic bus_rd(input logic [4:0] a, input logic sel_n, output logic [7:0] d, output logic ok);
      int n;
      n = 0;
      @(negedge clk);
      addr = a;
      cs_n = sel_n;
      repeat (2) @(negedge clk);
      rd_n = 1'b0;
      while (data_oe !== 1'b1 && n < 12) begin
         @(negedge clk);
         n++;
      end
      ok = (data_oe === 1'b1);
      repeat (2) @(negedge clk);
      d = data_out;
      repeat (3) @(negedge clk);
      rd_n = 1'b1;
      @(negedge clk);
      cs_n = 1'b1;
      finish_cycle();
   endtask
   // Write cycle; with mux set the address rides the data lines and is latched by the strobe.
   task automatic bus_wr(input logic [4:0] a, input logic [7:0] d, input logic mux);
      @(negedge clk);
      addr = a;
      data_in = mux ? {3'h0, a} : d;
      cs_n = 1'b0;
      if (mux) begin
         repeat (3) @(negedge clk);
         ale = 1'b0;
         repeat (3) @(negedge clk);
         addr = 5'h15;
         data_in = d;
      end
      repeat (2) @(negedge clk);
      wr_n = 1'b0;
      repeat (6) @(negedge clk);
      wr_n = 1'b1;
      @(negedge clk);
      cs_n = 1'b1;
      repeat (3) @(negedge clk);
      ale = 1'b1;
      finish_cycle();
   endtask
endmodule

// [sim/rtc_bus_interrupt_latch_tb.sv]
// Self-checking bench for the clock block: map, snapshot, run control and interrupt pin.
`timescale 1ns/1ns
`include "rtc_defines.svh"
module rtc_bus_interrupt_latch_tb;
   import rtc_pkg::*;
   logic clk_sys;
   logic rstn;
   logic xtal_in = 1'b0;
   logic pwr_down;
   logic rd_n;
   logic wr_n;
   logic cs_n;
   logic ale;
   logic [4:0] addr;
   logic [7:0] data_in;
   logic [7:0] data_out;
   logic data_oe;
   logic irq_out;
   logic irq_oe;
   wire irq_line;
   int err_total;
   int check_count;
   int cyc = 0;
   int t_fall;
   logic [7:0] rv;
   logic ok;
   ////////////////////////////////////////////////////////////////////////////////
   // Open-drain interrupt wire with its external pull-up.
   assign irq_line = irq_oe ? irq_out : 1'b1;
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   // Crystal runs at a quarter of the system clock, so one 100Hz tick is 1308 or 1312 cycles.
   always @(negedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc % 2 == 0) begin
         xtal_in <= ~xtal_in;
      end
   end
   rtc_core uut (.CLK_SYS(clk_sys), .RSTN(rstn), .XTAL_IN(xtal_in), .PWR_DOWN(pwr_down), .RD_N(rd_n),
      .WR_N(wr_n), .CS_N(cs_n), .ALE(ale), .ADDR(addr), .DATA_IN(data_in), .DATA_OUT(data_out),
      .DATA_OE(data_oe), .IRQ_OUT(irq_out), .IRQ_OE(irq_oe));
   rtc_host_model host (.clk(clk_sys), .data_out(data_out), .data_oe(data_oe), .rd_n(rd_n), .wr_n(wr_n),
      .cs_n(cs_n), .ale(ale), .addr(addr), .data_in(data_in));
   ////////////////////////////////////////////////////////////////////////////////
   // Shared compare, verdict and bus helpers.
   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %0t %s: saw %h expected %h", $time, msg, seen, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic timeout_hit();
      err_total++;
      $display("[FAIL] %0t wait ran out", $time);
      tally_and_finish();
   endtask
   task automatic rd(input logic [4:0] a, input logic [7:0] exp, input string msg);
      host.bus_rd(a, 1'b0, rv, ok);
      if (ok !== 1'b1) begin
         timeout_hit();
      end
      check(rv, exp, msg);
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      host.bus_wr(a, d, 1'b0);
   endtask
   // Waits for the interrupt wire to fall; a fall that never comes ends the run.
   task automatic wait_fall(input int lim);
      int n;
      n = 0;
      while (irq_line !== 1'b0 && n < lim) begin
         @(negedge clk_sys);
         n++;
      end
      if (irq_line !== 1'b0) begin
         timeout_hit();
      end
      t_fall = cyc;
   endtask
   task automatic stay_high(input int lim, input string msg);
      int lows;
      lows = 0;
      repeat (lim) begin
         @(negedge clk_sys);
         lows += (irq_line !== 1'b1);
      end
      check(8'(lows != 0), 8'h00, msg);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Scenarios.
   task automatic t_map();
      check({6'h0, data_oe, irq_line}, 8'h01, "idle pins");
      rd(`ADR_IRQ, 8'h00, "status at reset");
      rd(`ADR_CMD, 8'h00, "command read");
      rd(`ADR_HUND, 8'h00, "hundredths at reset");
      rd(`ADR_MONTH, 8'h01, "month at reset");
      wr(5'h12, 8'hff);
      rd(5'h12, 8'h00, "unused 12h");
      rd(5'h1f, 8'h00, "unused 1Fh");
      host.bus_rd(`ADR_HUND, 1'b1, rv, ok);
      check({7'h0, ok}, 8'h00, "drove without select");
      $display("test map done");
   endtask
   task automatic t_snap();
      wr(`ADR_MIN, 8'h2a);
      wr(`ADR_HOURS, 8'h8b);
      rd(`ADR_HUND, 8'h00, "hundredths");
      rd(`ADR_MIN, 8'h2a, "minutes");
      rd(`ADR_HOURS, 8'h8b, "pm hours");
      wr(`ADR_MIN, 8'h07);
      rd(`ADR_MIN, 8'h2a, "snapshot held");
      rd(`ADR_HUND, 8'h00, "hundredths");
      rd(`ADR_MIN, 8'h07, "new snapshot");
      $display("test snapshot done");
   endtask
   // Stop, load, start: the set-time procedure, then test mode on the seconds counter.
   task automatic t_run();
      logic [7:0] h;
      wr(`ADR_HUND, 8'h00);
      wr(`ADR_CMD, 8'h08);
      repeat (3000) @(negedge clk_sys);
      wr(`ADR_CMD, 8'h00);
      host.bus_rd(`ADR_HUND, 1'b0, h, ok);
      check(8'(h >= 2 && h <= 3), 8'h01, "ticks while running");
      repeat (3000) @(negedge clk_sys);
      rd(`ADR_HUND, h, "held while stopped");
      wr(`ADR_SEC, 8'h00);
      wr(`ADR_CMD, 8'h28);
      repeat (3000) @(negedge clk_sys);
      wr(`ADR_CMD, 8'h00);
      host.bus_rd(`ADR_HUND, 1'b0, h, ok);
      host.bus_rd(`ADR_SEC, 1'b0, h, ok);
      check(8'(h >= 2 && h <= 3), 8'h01, "seconds in test mode");
      $display("test run done");
   endtask
   task automatic t_irq();
      int t1;
      wr(`ADR_IRQ, 8'h02);
      wr(`ADR_CMD, 8'h18);
      wait_fall(1400);
      t1 = t_fall;
      rd(`ADR_IRQ, 8'h82, "cause and pending");
      check({7'h0, irq_line}, 8'h01, "released by read");
      wait_fall(1400);
      check(8'((t_fall - t1) >= 1306 && (t_fall - t1) <= 1314), 8'h01, "fall spacing");
      rd(`ADR_IRQ, 8'h82, "cause again");
      wr(`ADR_CMD, 8'h08);
      stay_high(1500, "line while disabled");
      rd(`ADR_IRQ, 8'h82, "flag while disabled");
      wr(`ADR_IRQ, 8'h00);
      host.bus_rd(`ADR_IRQ, 1'b0, rv, ok);
      wr(`ADR_CMD, 8'h18);
      stay_high(1500, "line with zero mask");
      rd(`ADR_IRQ, 8'h00, "zero mask status");
      $display("test interrupt done");
   endtask
   task automatic t_pdown();
      wr(`ADR_IRQ, 8'h02);
      pwr_down = 1'b1;
      repeat (4) @(negedge clk_sys);
      host.bus_rd(`ADR_IRQ, 1'b0, rv, ok);
      check({7'h0, ok}, 8'h00, "bus in power-down");
      wait_fall(1400);
      pwr_down = 1'b0;
      repeat (4) @(negedge clk_sys);
      rd(`ADR_IRQ, 8'h82, "flag kept in power-down");
      $display("test power-down done");
   endtask
   // Alarm on hundredths equal to 5 only; the minutes word goes in over the multiplexed bus.
   task automatic t_alarm();
      int t0;
      wr(`ADR_CMD, 8'h00);
      wr(`ADR_IRQ, 8'h00);
      host.bus_rd(`ADR_IRQ, 1'b0, rv, ok);
      wr(`ADR_ALARM_BASE, 8'h05);
      wr(`ADR_ALARM_BASE + 5'h1, 8'h40);
      for (int i = 2; i < 8; i++) begin
         host.bus_wr(`ADR_ALARM_BASE + 5'(i), 8'h80, i == 2);
      end
      rd(`ADR_ALARM_BASE + 5'h2, 8'h80, "latched address");
      wr(`ADR_HUND, 8'h00);
      wr(`ADR_IRQ, 8'h01);
      wr(`ADR_CMD, 8'h18);
      t0 = cyc;
      wait_fall(7000);
      check(8'((t_fall - t0) >= 5200 && (t_fall - t0) <= 6590), 8'h01, "alarm time");
      rd(`ADR_IRQ, 8'h81, "alarm cause");
      $display("test alarm done");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial begin
      rstn = 1'b0;
      pwr_down = 1'b0;
      err_total = 0;
      check_count = 0;
      repeat (2) @(negedge clk_sys);
      rstn = 1'b1;
      repeat (4) @(negedge clk_sys);
      t_map();
      t_snap();
      t_run();
      t_irq();
      t_pdown();
      t_alarm();
      tally_and_finish();
   end
endmodule
